// ===== mhr_pkg.sv
package mhr_pkg;
    localparam logic [15:0] MHR_WR_AREA_BASE = 16'h0000;
    localparam logic [15:0] MHR_SWITCH_ADDR = 16'h0FFD;
    localparam logic [15:0] MHR_INDICATOR_ADDR = 16'h0FFE;
    localparam logic [15:0] MHR_STATUS_ADDR = 16'h0FFF;
    localparam logic [15:0] MHR_RD_AREA_BASE = 16'h1000;
    localparam logic [15:0] MHR_KIND_ADDR = 16'h5003;
    localparam logic [15:0] MHR_NET_KIND_ADDR = 16'h5004;
    localparam logic [15:0] MHR_FAULT_ADDR = 16'h5005;
    localparam logic [7:0] MHR_FC_READ_HOLD = 8'h03;
    localparam logic [7:0] MHR_FC_READ_INPUT = 8'h04;
    localparam logic [7:0] MHR_BYTE_COUNT_ONE = 8'h02;
    localparam logic [15:0] MHR_FAULT_WAIT_RESET = 16'h0005;
    localparam logic [15:0] MHR_FAULT_NONE = 16'h0000;
    localparam int MHR_SUP_BIT = 3;
    localparam int MHR_SET_DEFAULT_BIT = 14;
    localparam int MHR_RESET_REQ_BIT = 15;

    typedef enum logic [2:0] {
        MHR_SETUP = 3'b000,
        MHR_NETWORK_INIT = 3'b001,
        MHR_WAIT_PROCESS = 3'b010,
        MHR_IDLE = 3'b011,
        MHR_PROCESS_ACTIVE = 3'b100,
        MHR_ERROR = 3'b101,
        MHR_RESERVED = 3'b110,
        MHR_EXCEPTION = 3'b111
    } mhr_state_t;

    // one register access from the serial front end
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] func;
        logic [15:0] addr;
        logic [15:0] wdata;
        logic last;
    } mhr_req_t;

    // module side inputs
    typedef struct packed {
        mhr_state_t state;
        logic supervised;
        logic set_default_req;
        logic reset_req;
        logic [15:0] fault_code;
    } mhr_core_t;
endpackage

// ===== mhr_sync.sv
`timescale 1ns/1ns
// two flop synchroniser for pin levels
module mhr_sync #(
    parameter int WIDTH = 10
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } mhr_sync_t;

    mhr_sync_t st;
    mhr_sync_t next_st;

    always_comb
    begin
        next_st.meta = async_in;
        next_st.stable = st.meta;
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            st <= '0;
        else
            st <= next_st;
    end

    assign sync_out = st.stable;
endmodule // mhr_sync

// ===== mhr_register_map.sv
`timescale 1ns/1ns
// How it works
// - input register read of 0x5005 answers byte count 2 and the fault code
// - write area goes to network only after its final register is written or a write with last set
// - switch register: first pin in bit 0, second pin in bit 15
// - indicator register shows the eight pins of the four indicators (a and b) in bits 0 to 7, 1 lit
// - status bits 0 to 2 carry the module state code
// - status bit 3 is set while another network device supervises
// - bit 14 asks for factory defaults; host writes 1 to clear it
// - bit 15 asks the host to reset the module
// - read area snapshot taken only when its first register is read
// - fault code 5 means waiting for application reset
// - writes to read-only registers are dropped without error
// - reads of undefined registers return zero
module mhr_register_map
    import mhr_pkg::*;
#(
    parameter int WR_WORDS = 16,
    parameter int RD_WORDS = 16,
    parameter logic [15:0] MODULE_KIND = 16'h0A01,   // arbitrary value
    parameter logic [15:0] NETWORK_KIND = 16'h0B02   // arbitrary value
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // register access from serial front end
    input wire mhr_pkg::mhr_req_t req,
    output logic rsp_valid,
    output logic [7:0] rsp_func,
    output logic [7:0] rsp_count,
    output logic [15:0] rsp_data,
    // pins
    input wire logic first_switch_pin,
    input wire logic second_switch_pin,
    input wire logic indicator_one_a,
    input wire logic indicator_one_b,
    input wire logic indicator_two_a,
    input wire logic indicator_two_b,
    input wire logic indicator_three_a,
    input wire logic indicator_three_b,
    input wire logic indicator_four_a,
    input wire logic indicator_four_b,
    // module core side
    input wire mhr_pkg::mhr_core_t core,
    input wire logic [RD_WORDS*16-1:0] net_rd_data,
    output logic [WR_WORDS*16-1:0] net_wr_data,
    output logic net_wr_commit,
    output logic [15:0] status_word
);
    import mhr_pkg::*;

    localparam logic [15:0] WR_LAST = MHR_WR_AREA_BASE + 16'(WR_WORDS - 1);
    localparam logic [15:0] RD_LAST = MHR_RD_AREA_BASE + 16'(RD_WORDS - 1);

    typedef struct packed {
        logic [WR_WORDS-1:0][15:0] wr_stage;
        logic [WR_WORDS-1:0][15:0] wr_net;
        logic [RD_WORDS-1:0][15:0] rd_snap;
        logic commit;
        logic set_default;
        logic reset_req;
        logic rsp_valid;
        logic [7:0] rsp_func;
        logic [7:0] rsp_count;
        logic [15:0] rsp_data;
        logic [15:0] status;
    } mhr_st_t;

    mhr_st_t st;
    mhr_st_t next_st;
    logic [9:0] pins;

    function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                      input logic [15:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    mhr_sync #(
        .WIDTH(10)
    ) u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .async_in({indicator_four_b, indicator_four_a, indicator_three_b,
                   indicator_three_a, indicator_two_b, indicator_two_a,
                   indicator_one_b, indicator_one_a, second_switch_pin,
                   first_switch_pin}),
        .sync_out(pins)
    );

    always_comb
    begin
        logic [15:0] rd_val;
        logic [15:0] wr_idx;
        logic [15:0] rd_idx;
        rd_val = 16'h0000;
        wr_idx = req.addr - MHR_WR_AREA_BASE;
        rd_idx = req.addr - MHR_RD_AREA_BASE;
        next_st = st;
        next_st.commit = 1'b0;
        next_st.rsp_valid = 1'b0;
        // hardware set wins over host clear
        if (req.wr && req.addr == MHR_STATUS_ADDR && req.wdata[MHR_SET_DEFAULT_BIT])
            next_st.set_default = 1'b0;
        if (core.set_default_req)
            next_st.set_default = 1'b1;
        next_st.reset_req = core.reset_req;
        if (req.wr && in_range(req.addr, MHR_WR_AREA_BASE, WR_LAST))
        begin
            next_st.wr_stage[wr_idx[$clog2(WR_WORDS+1)-1:0]] = req.wdata;
            if (req.addr == WR_LAST || req.last)
            begin
                next_st.wr_net = next_st.wr_stage;
                next_st.commit = 1'b1;
            end
        end
        // other writes, including read-only registers, are dropped
        if (req.rd)
        begin
            if (in_range(req.addr, MHR_WR_AREA_BASE, WR_LAST))
                rd_val = st.wr_stage[wr_idx[$clog2(WR_WORDS+1)-1:0]];
            else if (req.addr == MHR_SWITCH_ADDR)
                rd_val = {pins[1], 14'h0000, pins[0]};
            else if (req.addr == MHR_INDICATOR_ADDR)
                rd_val = {8'h00, pins[9:2]};
            else if (req.addr == MHR_STATUS_ADDR)
                rd_val = st.status;
            else if (req.addr == MHR_RD_AREA_BASE)
            begin
                next_st.rd_snap = net_rd_data;
                rd_val = net_rd_data[15:0];
            end
            else if (in_range(req.addr, MHR_RD_AREA_BASE, RD_LAST))
                rd_val = st.rd_snap[rd_idx[$clog2(RD_WORDS+1)-1:0]];
            else if (req.addr == MHR_KIND_ADDR)
                rd_val = MODULE_KIND;
            else if (req.addr == MHR_NET_KIND_ADDR)
                rd_val = NETWORK_KIND;
            else if (req.addr == MHR_FAULT_ADDR)
                rd_val = core.fault_code;
            else
                rd_val = 16'h0000;
            next_st.rsp_valid = 1'b1;
            next_st.rsp_func = req.func;
            next_st.rsp_count = MHR_BYTE_COUNT_ONE;
            next_st.rsp_data = rd_val;
        end
        next_st.status = 16'h0000;
        next_st.status[2:0] = core.state;
        next_st.status[MHR_SUP_BIT] = core.supervised;
        next_st.status[MHR_SET_DEFAULT_BIT] = next_st.set_default;
        next_st.status[MHR_RESET_REQ_BIT] = next_st.reset_req;
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            st <= '0;
        else
            st <= next_st;
    end

    assign rsp_valid = st.rsp_valid;
    assign rsp_func = st.rsp_func;
    assign rsp_count = st.rsp_count;
    assign rsp_data = st.rsp_data;
    assign net_wr_data = st.wr_net;
    assign net_wr_commit = st.commit;
    assign status_word = st.status;

    fault_read_a: assert property (@(posedge clk) disable iff (!reset_n)
        req.rd && req.addr == MHR_FAULT_ADDR |=> rsp_valid && rsp_count == MHR_BYTE_COUNT_ONE
        && rsp_data == $past(core.fault_code))
        else $error("fault code read answer wrong");
    commit_last_a: assert property (@(posedge clk) disable iff (!reset_n)
        net_wr_commit |-> $past(req.wr) && ($past(req.addr) == WR_LAST || $past(req.last)))
        else $error("write area committed early");
    hold_area_a: assert property (@(posedge clk) disable iff (!reset_n)
        !net_wr_commit |-> $stable(net_wr_data))
        else $error("write area changed without commit");
    switch_read_a: assert property (@(posedge clk) disable iff (!reset_n)
        req.rd && req.addr == MHR_SWITCH_ADDR |=> rsp_data[14:1] == 14'h0000)
        else $error("switch register reserved bits set");
    indicator_read_a: assert property (@(posedge clk) disable iff (!reset_n)
        req.rd && req.addr == MHR_INDICATOR_ADDR |=> rsp_data == {8'h00, $past(pins[9:2])})
        else $error("indicator register wrong");
    state_field_a: assert property (@(posedge clk) disable iff (!reset_n)
        1'b1 |=> status_word[2:0] == $past(core.state)
        && status_word[MHR_SUP_BIT] == $past(core.supervised))
        else $error("state or supervision field wrong");
    set_default_a: assert property (@(posedge clk) disable iff (!reset_n)
        core.set_default_req |=> status_word[MHR_SET_DEFAULT_BIT])
        else $error("set default request lost");
    reset_req_a: assert property (@(posedge clk) disable iff (!reset_n)
        1'b1 |=> status_word[MHR_RESET_REQ_BIT] == $past(core.reset_req))
        else $error("reset request bit wrong");
    snapshot_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        !(req.rd && req.addr == MHR_RD_AREA_BASE) |=> $stable(st.rd_snap))
        else $error("read area changed without first read");
    undefined_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
        req.rd && req.addr == 16'h3000 |=> rsp_data == 16'h0000)
        else $error("undefined register not zero");
    reserved_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
        1'b1 |-> status_word[13:4] == 10'h000)
        else $error("status reserved bits set");

    // addresses that hold a register of their own
    function automatic logic known_addr(input logic [15:0] a);
        return in_range(a, MHR_WR_AREA_BASE, WR_LAST) || in_range(a, MHR_RD_AREA_BASE, RD_LAST)
            || a == MHR_SWITCH_ADDR || a == MHR_INDICATOR_ADDR || a == MHR_STATUS_ADDR
            || a == MHR_KIND_ADDR || a == MHR_NET_KIND_ADDR || a == MHR_FAULT_ADDR;
    endfunction

    // a host read of one register address
    sequence reg_read_s(logic [15:0] a);
        req.rd && req.addr == a;
    endsequence

    // a host write of 1 to the set default bit
    sequence status_ack_s;
        req.wr && req.addr == MHR_STATUS_ADDR && req.wdata[MHR_SET_DEFAULT_BIT];
    endsequence

    rsp_follows_a: assert property (@(posedge clk) disable iff (!reset_n)
        1'b1 |=> rsp_valid == $past(req.rd))
        else $error("answer pulse does not follow read");

    func_echo_a: assert property (@(posedge clk) disable iff (!reset_n)
        req.rd |=> rsp_func == $past(req.func))
        else $error("function code not echoed");

    count_fixed_a: assert property (@(posedge clk) disable iff (!reset_n)
        rsp_valid |-> rsp_count == MHR_BYTE_COUNT_ONE)
        else $error("byte count wrong");

    commit_data_a: assert property (@(posedge clk) disable iff (!reset_n)
        net_wr_commit |-> net_wr_data == st.wr_stage)
        else $error("committed write area differs from staged data");

    commit_cause_a: assert property (@(posedge clk) disable iff (!reset_n)
        req.wr && req.addr == WR_LAST |=> net_wr_commit)
        else $error("final register write did not commit");

    switch_bits_a: assert property (@(posedge clk) disable iff (!reset_n)
        reg_read_s(MHR_SWITCH_ADDR) |=> rsp_data[0] == $past(pins[0])
        && rsp_data[15] == $past(pins[1]))
        else $error("switch pin bits wrong");

    indicator_top_a: assert property (@(posedge clk) disable iff (!reset_n)
        reg_read_s(MHR_INDICATOR_ADDR) |=> rsp_data[15:8] == 8'h00)
        else $error("indicator upper byte set");

    status_read_a: assert property (@(posedge clk) disable iff (!reset_n)
        reg_read_s(MHR_STATUS_ADDR) |=> rsp_data == $past(status_word))
        else $error("status read differs from status image");

    default_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
        status_ack_s ##0 !core.set_default_req |=> !status_word[MHR_SET_DEFAULT_BIT])
        else $error("set default acknowledge did not clear");

    default_keep_a: assert property (@(posedge clk) disable iff (!reset_n)
        status_word[MHR_SET_DEFAULT_BIT]
        && !(req.wr && req.addr == MHR_STATUS_ADDR && req.wdata[MHR_SET_DEFAULT_BIT])
        |=> status_word[MHR_SET_DEFAULT_BIT])
        else $error("set default bit lost without acknowledge");

    status_write_a: assert property (@(posedge clk) disable iff (!reset_n)
        req.wr && req.addr == MHR_STATUS_ADDR |=> status_word[2:0] == $past(core.state)
        && status_word[MHR_SUP_BIT] == $past(core.supervised))
        else $error("status write altered state or supervision");

    reset_rise_a: assert property (@(posedge clk) disable iff (!reset_n)
        core.reset_req && !status_word[MHR_RESET_REQ_BIT] |=> status_word[MHR_RESET_REQ_BIT])
        else $error("reset request not raised");

    snapshot_take_a: assert property (@(posedge clk) disable iff (!reset_n)
        reg_read_s(MHR_RD_AREA_BASE) |=> st.rd_snap == $past(net_rd_data)
        && rsp_data == $past(net_rd_data[15:0]))
        else $error("read area snapshot not taken");

    fault_wait_a: assert property (@(posedge clk) disable iff (!reset_n)
        reg_read_s(MHR_FAULT_ADDR) ##0 core.fault_code == MHR_FAULT_WAIT_RESET
        |=> rsp_data == MHR_FAULT_WAIT_RESET)
        else $error("wait for reset code not reported");

    fault_none_a: assert property (@(posedge clk) disable iff (!reset_n)
        reg_read_s(MHR_FAULT_ADDR) ##0 core.fault_code == MHR_FAULT_NONE
        |=> rsp_data == MHR_FAULT_NONE)
        else $error("no fault code not reported");

    ro_write_a: assert property (@(posedge clk) disable iff (!reset_n)
        req.wr && !in_range(req.addr, MHR_WR_AREA_BASE, WR_LAST)
        |=> !net_wr_commit && $stable(st.wr_stage))
        else $error("write outside write area changed it");

    write_silent_a: assert property (@(posedge clk) disable iff (!reset_n)
        req.wr && !req.rd |=> !rsp_valid)
        else $error("write produced an answer");

    unknown_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
        req.rd && !known_addr(req.addr) |=> rsp_data == 16'h0000)
        else $error("undefined address read not zero");

    kind_read_a: assert property (@(posedge clk) disable iff (!reset_n)
        reg_read_s(MHR_KIND_ADDR) |=> rsp_data == MODULE_KIND)
        else $error("module kind code wrong");

endmodule // mhr_register_map

// ===== mhr_host_model.sv
`timescale 1ns/1ns
module mhr_host_model
    import mhr_pkg::*;
(
    // clock
    input wire logic clk,
    // request to module
    output mhr_pkg::mhr_req_t req,
    // answer from module
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_func,
    input wire logic [7:0] rsp_count,
    input wire logic [15:0] rsp_data
);
    initial req = '0;
    // one word access, held for exactly the taking edge
    task automatic acc(input logic r, input logic [7:0] f, input logic [15:0] a,
                       input logic [15:0] d, input logic l, output logic [15:0] q,
                       output logic ok);
        @(posedge clk);
        req <= '{rd: r, wr: !r, func: f, addr: a, wdata: d, last: l};
        @(posedge clk);
        req <= '0;
        @(posedge clk);
        q = rsp_data;
        ok = (rsp_valid === r) && (!r || (rsp_count === MHR_BYTE_COUNT_ONE && rsp_func === f));
    endtask
    // acknowledge the factory default request
    task automatic ack_default;
        logic [15:0] q;
        logic ok;
        acc(1'b0, 8'h06, MHR_STATUS_ADDR, 16'h4000, 1'b0, q, ok);
    endtask
    // code 0 needs nothing, code 5 asks for a reset, other codes need a reset and full reinit
    task automatic fault_service(output logic [15:0] code, output logic do_reset,
                                 output logic reinit);
        logic ok;
        acc(1'b1, MHR_FC_READ_INPUT, MHR_FAULT_ADDR, 16'h0000, 1'b0, code, ok);
        do_reset = (code !== MHR_FAULT_NONE);
        reinit = do_reset && (code !== MHR_FAULT_WAIT_RESET);
    endtask
endmodule // mhr_host_model

// ===== modbus_host_register_map_test.sv
`timescale 1ns/1ns
module modbus_host_register_map_test;
    import mhr_pkg::*;
    typedef struct packed {logic [7:0] f; logic [15:0] a; logic [15:0] e;} mhr_row_t;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    mhr_req_t req;
    logic rsp_valid, net_wr_commit, ok, dr, ri;
    logic [7:0] rsp_func, rsp_count;
    logic [15:0] rsp_data, status_word, q;
    logic [9:0] pins = '0;
    mhr_core_t core = '0;
    logic [63:0] net_rd_data = '0;
    logic [63:0] net_wr_data, seen_wr;
    int failures = 0;
    int total_checks = 0;
    int commits = 0;
    mhr_row_t rows [8];
    always #2 clk = ~clk;
    always @(posedge clk)
        if (net_wr_commit === 1'b1)
        begin
            commits++;
            seen_wr = net_wr_data;
        end
    mhr_register_map #(.WR_WORDS(4), .RD_WORDS(4)) u_mhr_register_map (.clk(clk),
        .reset_n(reset_n), .req(req), .rsp_valid(rsp_valid), .rsp_func(rsp_func),
        .rsp_count(rsp_count), .rsp_data(rsp_data), .first_switch_pin(pins[0]),
        .second_switch_pin(pins[1]), .indicator_one_a(pins[2]), .indicator_one_b(pins[3]),
        .indicator_two_a(pins[4]), .indicator_two_b(pins[5]), .indicator_three_a(pins[6]),
        .indicator_three_b(pins[7]), .indicator_four_a(pins[8]), .indicator_four_b(pins[9]),
        .core(core), .net_rd_data(net_rd_data), .net_wr_data(net_wr_data),
        .net_wr_commit(net_wr_commit), .status_word(status_word));
    mhr_host_model u_mhr_host_model (.clk(clk), .req(req), .rsp_valid(rsp_valid),
        .rsp_func(rsp_func), .rsp_count(rsp_count), .rsp_data(rsp_data));
    task automatic chk(input string n, input logic [79:0] s, input logic [79:0] e);
        total_checks++;
        if (s !== e)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic go(input logic r, input logic [7:0] f, input logic [15:0] a,
                      input logic [15:0] d, input logic l);
        u_mhr_host_model.acc(r, f, a, d, l, q, ok);
        chk("answer", ok, 1'b1);
    endtask
    task automatic close_out;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        repeat (5000) @(posedge clk);
        failures++;
        close_out;
    end
    initial
    begin
        rows = '{'{8'h03, 16'h0FFD, 16'h8001}, '{8'h03, 16'h0FFE, 16'h004D},
                 '{8'h03, 16'h0FFF, 16'h800C}, '{8'h04, 16'h5003, 16'h0A01},
                 '{8'h04, 16'h5004, 16'h0B02}, '{8'h04, 16'h5005, 16'h0005},
                 '{8'h03, 16'h3000, 16'h0000}, '{8'h04, 16'h5100, 16'h0000}};
        repeat (20) @(posedge clk);
        chk("reset outputs", {rsp_valid, net_wr_commit, status_word}, '0);
        reset_n <= 1'b1;
        pins <= 10'h137;
        core <= '{MHR_PROCESS_ACTIVE, 1'b1, 1'b0, 1'b1, 16'h0005};
        repeat (4) @(posedge clk);
        foreach (rows[i])
        begin
            go(1'b1, rows[i].f, rows[i].a, '0, 1'b0);
            chk("row read", q, rows[i].e);
        end
        for (int s = 0; s < 8; s++)
        begin
            core.state <= mhr_state_t'(s);
            go(1'b1, MHR_FC_READ_HOLD, MHR_STATUS_ADDR, '0, 1'b0);
            chk("state", q[2:0], s[2:0]);
        end
        for (int w = 0; w < 3; w++)
            go(1'b0, 8'h10, w[15:0], 16'h00A0 + w[15:0], 1'b0);
        @(posedge clk);
        chk("held back", commits, 0);
        go(1'b0, 8'h10, 16'h0003, 16'h00A3, 1'b0);
        @(posedge clk);
        chk("commit data", {commits[7:0], seen_wr}, {8'd1, 64'h00A3_00A2_00A1_00A0});
        go(1'b0, 8'h10, 16'h0000, 16'h00B0, 1'b1);
        @(posedge clk);
        chk("last commit", {commits[7:0], seen_wr}, {8'd2, 64'h00A3_00A2_00A1_00B0});
        net_rd_data <= 64'h1114_1113_1112_1111;
        go(1'b1, MHR_FC_READ_HOLD, MHR_RD_AREA_BASE, '0, 1'b0);
        chk("snapshot", q, 16'h1111);
        net_rd_data <= 64'h2224_2223_2222_2221;
        go(1'b1, MHR_FC_READ_HOLD, 16'h1001, '0, 1'b0);
        chk("snapshot held", q, 16'h1112);
        go(1'b1, MHR_FC_READ_HOLD, MHR_RD_AREA_BASE, '0, 1'b0);
        chk("snapshot new", q, 16'h2221);
        go(1'b0, 8'h06, MHR_INDICATOR_ADDR, 16'hFFFF, 1'b0);
        go(1'b1, MHR_FC_READ_HOLD, MHR_INDICATOR_ADDR, '0, 1'b0);
        chk("ro write", q, 16'h004D);
        go(1'b0, 8'h06, MHR_STATUS_ADDR, 16'h3FF0, 1'b0);
        go(1'b1, MHR_FC_READ_HOLD, MHR_STATUS_ADDR, '0, 1'b0);
        chk("status write", q, 16'h800F);
        chk("status word", status_word, 16'h800F);
        core.set_default_req <= 1'b1;
        @(posedge clk);
        core.set_default_req <= 1'b0;
        go(1'b1, MHR_FC_READ_HOLD, MHR_STATUS_ADDR, '0, 1'b0);
        chk("default req", q, 16'hC00F);
        chk("status word set", status_word, 16'hC00F);
        u_mhr_host_model.ack_default;
        go(1'b1, MHR_FC_READ_HOLD, MHR_STATUS_ADDR, '0, 1'b0);
        chk("default ack", q, 16'h800F);
        u_mhr_host_model.fault_service(q, dr, ri);
        chk("wait reset", {q, dr, ri}, {16'h0005, 2'b10});
        core.fault_code <= 16'h0001;
        u_mhr_host_model.fault_service(q, dr, ri);
        chk("fatal fault", {q, dr, ri}, {16'h0001, 2'b11});
        close_out;
    end
endmodule // modbus_host_register_map_test
